// ---- bench/seea_bus_master.sv ----
// Two-wire bus master model: drives the serial clock, pulls the data line low.
// Assumes a pull-up resolves the data line outside; bit period 125 ns, clock idles high.
module seea_bus_master (
    output logic scl_o,
    output logic sda_low_o,
    input  wire  sda_i
);
    timeunit 1ns;
    timeprecision 100ps;
    event       res_ev;
    logic [8:0] res;
    logic [7:0] sh;
    logic       s;
    bit         quiet = 1'b0;
    initial {scl_o, sda_low_o} = 2'b10;
    // Data moves only in the middle of the low phase, sampled mid high phase
    task automatic clk_bit(input logic b);
        sda_low_o = !b;
        #31.25 scl_o = 1'b1;
        #31.25 s = sda_i;
        sh = {sh[6:0], s};
        #31.25 scl_o = 1'b0;
        #31.25;
    endtask
    task automatic start();
        sda_low_o = 1'b0;
        #31.25 scl_o = 1'b1;
        #31.25 sda_low_o = 1'b1;
        #31.25 scl_o = 1'b0;
        #31.25;
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        #31.25 scl_o = 1'b1;
        #31.25 sda_low_o = 1'b0;
        #62.5;
    endtask
    // A read sends all ones so the slave owns the line; ack_bit is our answer on a read
    task automatic xfer(input logic [7:0] d, input logic rd, input logic ack_bit, output logic [8:0] r);
        for (int i = 7; i >= 0; i--) clk_bit(d[i]);
        res = {rd, sh};
        clk_bit(ack_bit);
        if (!rd) res = {8'h00, !s};
        r = res;
        if (!quiet) ->res_ev;
    endtask
endmodule // seea_bus_master

// ---- bench/seea_slave_monitor.sv ----
// Checker for the two-wire memory slave, bound to the slave's own ports.
// Assumes one clock domain with a synchronous active-high reset.
module seea_slave_monitor #(
    parameter WR_CYCLES = 50
) (
    input wire sys_clk_i,
    input wire sys_rst_i,
    input wire scl_i,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe_n_o,
    input wire busy_o
);
    timeunit 1ns;
    timeprecision 100ps;
    reg        sda_q_r;
    reg [3:0]  since_stop_r;
    reg [31:0] busy_cnt_r;
    // Stop is seen on the raw wires, so the slave's synchroniser lag is allowed for below
    always @(posedge sys_clk_i)
    begin
        sda_q_r <= sda_i;
        busy_cnt_r <= (sys_rst_i || !busy_o) ? 32'h0 : busy_cnt_r + 32'h1;
        if (sys_rst_i || (scl_i && sda_i && !sda_q_r))
            since_stop_r <= 4'h0;
        else if (since_stop_r != 4'hf)
            since_stop_r <= since_stop_r + 4'h1;
    end
    default clocking mon_cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_stop;
        scl_i && $rose(sda_i);
    endsequence
    sequence s_busy_hold;
        busy_o [*8];
    endsequence
    chk_drive_low: assert property (!sda_oe_n_o |-> !sda_o) else $error("sda driven high");
    chk_busy_no_ack: assert property (busy_o |-> sda_oe_n_o) else $error("ack while busy");
    chk_busy_after_stop: assert property ($rose(busy_o) |-> since_stop_r <= 4'hc) else $error("busy without stop");
    chk_busy_holds: assert property ($rose(busy_o) |-> s_busy_hold) else $error("busy too short");
    chk_busy_length: assert property ($fell(busy_o) |-> busy_cnt_r >= WR_CYCLES) else $error("cycle cut");
    chk_edge_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i) else $error("sda moved, scl high");
    chk_release_stop: assert property (s_stop |=> sda_oe_n_o [*4]) else $error("held after stop");
    // A read ack followed by an all-zero byte keeps the line low for nine bit times
    chk_drive_bounded: assert property ($fell(sda_oe_n_o) |-> ##[1:120] sda_oe_n_o) else $error("held");
endmodule // seea_slave_monitor
bind seea_slave seea_slave_monitor #(.WR_CYCLES(WR_CYCLES)) u_seea_slave_monitor (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .busy_o(busy_o));

// ---- bench/tb_seea_slave.sv ----
// Self-checking bench: the master model drives the slave, results checked from a queue.
// Assumes the bound checker and the master model are compiled alongside.
module tb_seea_slave;
    timeunit 1ns;
    timeprecision 100ps;
    logic       sys_clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic       wp_r      = 1'b0;
    logic [2:0] cs_r      = 3'h0;
    logic [2:0] dev_r     = 3'h0;
    logic [7:0] mem_r [0:127];
    logic [6:0] ptr_r;
    logic [8:0] e_r, r_r, q_r;
    logic [8:0] exp_q [$];
    integer     seed = 45, n_errors = 0, n_tests = 0;
    wire        scl_w, sda_low_w, sda_o, sda_oe_n_o, busy_o;
    wire        rp_sda_w, rp_oe_n_w, rp_busy_w;
    wire        sda_w = (sda_low_w || (!sda_oe_n_o && !sda_o) || (!rp_oe_n_w && !rp_sda_w)) ? 1'b0 : 1'b1;
    seea_slave #(.REDUCED_PIN(0), .WR_CYCLES(400)) u_seea_slave (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .chip_select_bit0_i(cs_r[0]),
        .chip_select_bit1_i(cs_r[1]), .chip_select_bit2_i(cs_r[2]), .write_protect_i(wp_r), .busy_o(busy_o));
    // Reduced-pin part on the same bus: its third strap and protect pin must be ignored
    seea_slave #(.REDUCED_PIN(1), .WR_CYCLES(400)) u_seea_slave_rp (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .scl_i(scl_w), .sda_i(sda_w), .sda_o(rp_sda_w), .sda_oe_n_o(rp_oe_n_w), .chip_select_bit0_i(~cs_r[0]),
        .chip_select_bit1_i(cs_r[1]), .chip_select_bit2_i(1'b1), .write_protect_i(wp_r), .busy_o(rp_busy_w));
    seea_bus_master bm (.scl_o(scl_w), .sda_low_o(sda_low_w), .sda_i(sda_w));
    initial forever #5 sys_clk_i = !sys_clk_i;
    initial #400000 timeout();
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic miss(input logic [7:0] g, input logic [7:0] e);
        n_errors++;
        $display("unexpected result at %0t: got %h want %h", $time, g, e);
    endtask
    task automatic timeout();
        miss(8'h00, 8'h01);
        report_and_stop();
    endtask
    task automatic cmp_ack(input logic e, input logic g);
        n_tests++;
        if (g !== e) miss({7'h00, g}, {7'h00, e});
    endtask
    task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) miss(g, e);
    endtask
    task automatic wb(input logic [7:0] d, input logic ack);
        exp_q.push_back({8'h00, ack});
        bm.xfer(d, 1'b0, 1'b1, r_r);
    endtask
    // A write into the model follows the in-page wrap; protected writes leave it alone
    task automatic page_wr(input logic [6:0] addr, input integer n);
        integer i;
        bm.start();
        wb({4'ha, dev_r, 1'b0}, 1'b1);
        wb({1'b0, addr}, 1'b1);
        for (i = 0; i < n; i++)
        begin
            e_r = {1'b0, 8'($random(seed))};
            if (!wp_r || dev_r != cs_r)
                mem_r[{addr[6:4], addr[3:0] + i[3:0]}] = e_r[7:0];
            wb(e_r[7:0], 1'b1);
        end
        bm.stop();
        cmp_ack(1'b1, (dev_r == cs_r) ? busy_o : rp_busy_w);
        r_r = 9'h000;
        for (i = 0; i < 50 && !r_r[0]; i++)
        begin
            if (i == 0) exp_q.push_back(9'h000);
            bm.quiet = (i > 0);
            bm.start();
            bm.xfer({4'ha, dev_r, 1'b0}, 1'b0, 1'b1, r_r);
            bm.stop();
        end
        bm.quiet = 1'b0;
        if (!r_r[0]) timeout();
        cmp_ack(1'b0, (dev_r == cs_r) ? busy_o : rp_busy_w);
    endtask
    task automatic seq_rd(input logic rnd, input logic [6:0] addr, input integer n);
        integer i;
        bm.start();
        if (rnd)
        begin
            wb({4'ha, dev_r, 1'b0}, 1'b1);
            wb({1'b0, addr}, 1'b1);
            ptr_r = addr;
            bm.start();
        end
        wb({4'ha, dev_r, 1'b1}, 1'b1);
        for (i = 0; i < n; i++)
        begin
            exp_q.push_back({1'b1, mem_r[ptr_r]});
            ptr_r = ptr_r + 7'h01;
            bm.xfer(8'hff, 1'b1, i == n - 1, r_r);
        end
        bm.stop();
    endtask
    initial
    forever
    begin
        @(bm.res_ev);
        q_r = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1xx;
        if (q_r[8]) cmp_byte(q_r[7:0], bm.res[7:0]);
        else cmp_ack(q_r[0], bm.res[0]);
    end
    initial
    begin
        cs_r = 3'($random(seed));
        dev_r = cs_r;
        repeat (16) @(posedge sys_clk_i);
        #1 sys_rst_i = 1'b0;
        repeat (4) @(posedge sys_clk_i);
        bm.start();
        wb({4'h5, cs_r, 1'b0}, 1'b0);
        bm.start();
        wb({4'ha, ~cs_r, 1'b1}, 1'b0);
        bm.stop();
        $display("test address match done");
        page_wr(7'h00, 2);
        page_wr(7'h7e, 18);
        $display("test page write done");
        @(posedge sys_clk_i) #1 wp_r = 1'b1;
        page_wr(7'h70, 1);
        dev_r = {1'b0, cs_r[1], ~cs_r[0]};
        page_wr(7'h40, 3);
        seq_rd(1'b1, 7'h40, 3);
        dev_r = cs_r;
        @(posedge sys_clk_i) #1 wp_r = 1'b0;
        $display("test write protect done");
        seq_rd(1'b1, 7'h70, 17);
        seq_rd(1'b0, 7'h00, 1);
        $display("test reads done");
        report_and_stop();
    end
endmodule // tb_seea_slave

// ---- rtl/seea_consts.vh ----
// Constants for the two-wire serial memory slave.
// Assumes inclusion by bare name from the design files.
`ifndef SEEA_CONSTS_VH
`define SEEA_CONSTS_VH
`define SEEA_DEV_CODE      4'ha
`define SEEA_ADDR_W        7
`define SEEA_PAGE_W        4
`define SEEA_MEM_DEPTH     128
`define SEEA_CLK_MHZ       100
`define SEEA_WR_TIME_US    5000
`define SEEA_WR_CYCLES     (`SEEA_WR_TIME_US * `SEEA_CLK_MHZ)
`define SEEA_BIT_CNT_W     4
`endif

// ---- rtl/seea_mem.v ----
// Byte-wide memory array with registered read data.
// Assumes one clock domain; write and read ports independent.
module seea_mem #(
    parameter AW = 7,
    parameter DW = 8
) (
    input  wire          sys_clk_i,
    input  wire          we_i,
    input  wire [AW-1:0] waddr_i,
    input  wire [DW-1:0] wdata_i,
    input  wire [AW-1:0] raddr_i,
    output reg  [DW-1:0] rdata_o
);
    reg [DW-1:0] mem_r [0:(1<<AW)-1];

    always @(posedge sys_clk_i)
    begin
        if (we_i)
        begin
            mem_r[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_r[raddr_i];
    end
endmodule // seea_mem

// ---- rtl/seea_slave.v ----
// Two-wire bus slave for a 128-byte memory with 16-byte page buffer.
// Assumes SCL/SDA and straps come from outside the clock domain; SDA is open drain.
`include "seea_consts.vh"

// Behaviour
// RL1 - Answer only control bytes with code 1010 and matching chip select straps.
// RL2 - Write control byte has low direction bit; acknowledge on ninth clock.
// RL3 - Byte after write control byte loads address pointer; acknowledge, then accept data.
// RL4 - Stop after write data starts timed write; no acknowledges until done.
// RL5 - With protection, still acknowledge and run full busy time, array unchanged.
// RL6 - Buffer up to 15 more data bytes; commit only at Stop.
// RL7 - Each written data byte increments only low four pointer bits.
// RL8 - Beyond 16 bytes the page offset wraps, overwriting earlier buffered bytes.
// RL9 - Page writes crossing a page boundary wrap to the start of that page.
// RL10 - Protect input high blocks all writes; low permits all.
// RL11 - Reduced-pin variant has no protect input; writes always enabled.
// RL12 - Master polls with Start and write control byte until acknowledged.
// RL13 - After write cycle completes, polling control byte is acknowledged.
// RL14 - Direction bit one selects read after acknowledge.
// RL15 - Current-address read sends byte one past last accessed address.
// RL16 - Master ends read with no-acknowledge and Stop; device releases data line.
// RL17 - Repeated Start after word address aborts write; pointer keeps new address.
// RL18 - After a read, pointer points past the last byte transmitted.
// RL19 - Master acknowledge makes the device send the next sequential byte.
// RL20 - Read increments the full seven-bit pointer, wrapping 7F to 00.
// RL21 - Sequential read never leaves this device's space.
// RL22 - Reduced-pin variant is addressed with top chip select bit zero.
// RL23 - Write cycle lasts a parameter count of clocks; control bytes ignored.
module seea_slave #(
    parameter REDUCED_PIN = 0,
    parameter WR_CYCLES   = `SEEA_WR_CYCLES
) (
    input  wire sys_clk_i,
    input  wire sys_rst_i,
    input  wire scl_i,
    input  wire sda_i,
    output reg  sda_o,
    output reg  sda_oe_n_o,
    input  wire chip_select_bit0_i,
    input  wire chip_select_bit1_i,
    input  wire chip_select_bit2_i,
    input  wire write_protect_i,
    output reg  busy_o
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_CTRL  = 3'h1;
    localparam ST_WADDR = 3'h2;
    localparam ST_WDATA = 3'h3;
    localparam ST_RDATA = 3'h4;
    localparam ST_ACK   = 3'h5;
    localparam ST_MACK  = 3'h6;
    localparam ST_SKIP  = 3'h7;

    // Two-flop synchronisers; only the second stage is looked at
    reg [1:0] scl_s_r;
    reg [1:0] sda_s_r;
    reg [1:0] cs_a_r;
    reg [1:0] cs_b_r;
    reg [1:0] cs_c_r;
    reg [1:0] wp_s_r;
    reg       scl_d_r;
    reg       sda_d_r;

    always @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            cs_a_r  <= 2'h0;
            cs_b_r  <= 2'h0;
            cs_c_r  <= 2'h0;
            wp_s_r  <= 2'h0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_s_r <= {scl_s_r[0], scl_i};
            sda_s_r <= {sda_s_r[0], sda_i};
            cs_a_r  <= {cs_a_r[0], chip_select_bit0_i};
            cs_b_r  <= {cs_b_r[0], chip_select_bit1_i};
            cs_c_r  <= {cs_c_r[0], chip_select_bit2_i};
            wp_s_r  <= {wp_s_r[0], write_protect_i};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end

    wire scl_w   = scl_s_r[1];
    wire sda_w   = sda_s_r[1];
    wire scl_rise = scl_w & ~scl_d_r;
    wire scl_fall = ~scl_w & scl_d_r;
    wire start_w = scl_w & scl_d_r & sda_d_r & ~sda_w;
    wire stop_w  = scl_w & scl_d_r & ~sda_d_r & sda_w;
    // Reduced-pin variant ignores the protect pin and has no third strap
    wire protect_w = (REDUCED_PIN != 0) ? 1'b0 : wp_s_r[1];                    // [RL10] [RL11]
    wire cs2_w     = (REDUCED_PIN != 0) ? 1'b0 : cs_c_r[1];                    // [RL22]

    reg [2:0]  state_r;
    reg [2:0]  ret_r;
    reg [3:0]  bit_cnt_r;
    reg [7:0]  shift_r;
    reg [6:0]  ptr_r;
    reg        rd_mode_r;
    reg [7:0]  page_buf_r [0:15];
    reg [15:0] page_vld_r;
    reg        commit_r;
    reg [4:0]  commit_idx_r;
    reg [3:0]  commit_page_r;
    reg        commit_prot_r;
    reg [31:0] busy_cnt_r;
    reg        pend_r;
    wire [7:0] rdata_w;

    function [6:0] seea_page_inc;
        input [6:0] a;
        begin
            seea_page_inc = {a[6:4], a[3:0] + 4'h1};
        end
    endfunction

    wire        mem_we_w   = commit_r & ~commit_prot_r & page_vld_r[commit_idx_r[3:0]];
    wire [6:0]  mem_wa_w   = {commit_page_r[2:0], commit_idx_r[3:0]};
    wire        busy_w     = commit_r | (busy_cnt_r != 32'h0);

    seea_mem #(
        .AW (`SEEA_ADDR_W),
        .DW (8)
    ) u_mem (
        .sys_clk_i (sys_clk_i),
        .we_i      (mem_we_w),
        .waddr_i   (mem_wa_w),
        .wdata_i   (page_buf_r[commit_idx_r[3:0]]),
        .raddr_i   (ptr_r),
        .rdata_o   (rdata_w)
    );

    integer i;

    always @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            state_r       <= ST_IDLE;
            ret_r         <= ST_IDLE;
            bit_cnt_r     <= 4'h0;
            shift_r       <= 8'h00;
            ptr_r         <= 7'h00;
            rd_mode_r     <= 1'b0;
            page_vld_r    <= 16'h0000;
            commit_r      <= 1'b0;
            commit_idx_r  <= 5'h00;
            commit_page_r <= 4'h0;
            commit_prot_r <= 1'b0;
            busy_cnt_r    <= 32'h0;
            pend_r        <= 1'b0;
            sda_o         <= 1'b1;
            sda_oe_n_o    <= 1'b1;
            busy_o        <= 1'b0;
            for (i = 0; i < 16; i = i + 1)
            begin
                page_buf_r[i] <= 8'h00;
            end
        end
        else
        begin
            busy_o <= busy_w;
            // Commit walks the 16 buffer slots, then the timed wait runs
            if (commit_r)
            begin
                if (commit_idx_r == 5'h0f)
                begin
                    commit_r   <= 1'b0;
                    page_vld_r <= 16'h0000;
                    busy_cnt_r <= WR_CYCLES;                                   // [RL23] [RL5]
                end
                commit_idx_r <= commit_idx_r + 5'h01;                          // [RL4]
            end
            else if (busy_cnt_r != 32'h0)
            begin
                busy_cnt_r <= busy_cnt_r - 32'h1;
            end

            if (start_w)
            begin
                // Repeated Start drops any buffered bytes; pointer already holds the new address
                // A commit in flight clears the valid bits itself; do not undo that here
                if (!commit_r)
                begin
                    page_vld_r <= 16'h0000;                                    // [RL17]
                end
                pend_r     <= 1'b0;
                state_r    <= ST_CTRL;
                bit_cnt_r  <= 4'h0;
                sda_oe_n_o <= 1'b1;
            end
            else if (stop_w)
            begin
                if (pend_r && !busy_w)
                begin
                    commit_r      <= 1'b1;                                     // [RL4] [RL6]
                    commit_idx_r  <= 5'h00;
                    commit_page_r <= {1'b0, ptr_r[6:4]};
                    commit_prot_r <= protect_w;                                // [RL5] [RL10]
                end
                pend_r     <= 1'b0;
                state_r    <= ST_IDLE;
                sda_oe_n_o <= 1'b1;                                            // [RL16]
            end
            else
            begin
                case (state_r)
                    ST_CTRL, ST_WADDR, ST_WDATA:
                    begin
                        if (scl_rise)
                        begin
                            shift_r   <= {shift_r[6:0], sda_w};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_r == 4'h8)
                        begin
                            bit_cnt_r <= 4'h0;
                            state_r   <= ST_ACK;
                            if (state_r == ST_CTRL)
                            begin
                                if (shift_r[7:4] == `SEEA_DEV_CODE && !busy_w && !busy_o &&
                                    shift_r[3:1] == {cs2_w, cs_b_r[1], cs_a_r[1]})  // [RL1] [RL13]
                                begin
                                    sda_oe_n_o <= 1'b0;                        // [RL2]
                                    sda_o      <= 1'b0;
                                    rd_mode_r  <= shift_r[0];                  // [RL14]
                                    ret_r      <= shift_r[0] ? ST_RDATA : ST_WADDR;
                                end
                                else
                                begin
                                    state_r <= ST_SKIP;                        // [RL4] [RL23] [RL12]
                                end
                            end
                            else if (state_r == ST_WADDR)
                            begin
                                ptr_r      <= shift_r[6:0];                    // [RL3]
                                sda_oe_n_o <= 1'b0;
                                sda_o      <= 1'b0;
                                ret_r      <= ST_WDATA;
                            end
                            else
                            begin
                                page_buf_r[ptr_r[3:0]] <= shift_r;             // [RL8]
                                page_vld_r[ptr_r[3:0]] <= 1'b1;                // [RL6]
                                ptr_r      <= seea_page_inc(ptr_r);           // [RL7] [RL9]
                                pend_r     <= 1'b1;
                                sda_oe_n_o <= 1'b0;                            // [RL5]
                                sda_o      <= 1'b0;
                                ret_r      <= ST_WDATA;
                            end
                        end
                    end
                    ST_ACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe_n_o <= 1'b1;
                            state_r    <= ret_r;
                            bit_cnt_r  <= 4'h0;
                            if (rd_mode_r && ret_r == ST_RDATA)
                            begin
                                // Read data reg follows the pointer; lead bit driven now
                                shift_r    <= rdata_w;                         // [RL15]
                                sda_oe_n_o <= rdata_w[7];
                                sda_o      <= 1'b0;
                                ptr_r      <= ptr_r + 7'h01;                   // [RL18] [RL20] [RL21]
                            end
                        end
                    end
                    ST_RDATA:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_cnt_r == 4'h7)
                            begin
                                sda_oe_n_o <= 1'b1;
                                state_r    <= ST_MACK;
                            end
                            else
                            begin
                                shift_r    <= {shift_r[6:0], 1'b1};
                                sda_oe_n_o <= shift_r[6];
                                bit_cnt_r  <= bit_cnt_r + 4'h1;
                            end
                        end
                    end
                    ST_MACK:
                    begin
                        if (scl_rise)
                        begin
                            // Master low means acknowledge: continue; high means done
                            state_r <= sda_w ? ST_SKIP : ST_ACK;               // [RL19] [RL16]
                            ret_r   <= ST_RDATA;
                        end
                    end
                    default:
                    begin
                        sda_oe_n_o <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule // seea_slave
